// [logic/config_startup_sequencer.v]
// Function
// - Release tristate hold at programmed phase
// - Done setting releases tristate on done input
// - Done input is pin or pipelined copy
// - Assert write enable at programmed phase
// - Block memory access blocked before enable
// - Done setting asserts write enable on done
// - Keep setting leaves write enable unchanged
// - Optional stall until all clock managers lock
// - Optional stall until impedance match asserts
// - Drive done high actively when enabled
// - Security levels refuse readback; levels 2 and 3 also refuse partial
// - Persist keeps configuration pins dedicated
// - Phase clock from cclk, user, scan
// - Master modes drive cclk from oscillator
// - Hold 32-bit user identification register
// - Release done at programmed phase, pipeline delays
// - Pipelined done waits line high, next edge
`timescale 1ns/1ps
`include "startup_defs.vh"

module config_startup_sequencer (
  input  wire                        clk,
  input  wire                        rst,
  // APB slave
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [11:0]                 paddr,
  input  wire [31:0]                 pwdata,
  output reg  [31:0]                 prdata,
  output reg                         pready,
  output reg                         pslverr,
  // Pins and external status
  input  wire                        done_pin_in,
  output reg                         done_pin_out,
  output reg                         done_pin_oe,
  output reg                         cclk_pin_out,
  output reg                         cclk_pin_oe,
  input  wire                        user_startup_clock,
  input  wire                        scan_test_clock,
  input  wire [`CLOCK_MANAGERS-1:0]  clock_manager_locked,
  input  wire [`IMPEDANCE_BANKS-1:0] impedance_calibration_match,
  // Requests from the configuration port logic, same clock
  input  wire                        readback_request,
  input  wire                        partial_request,
  // Global controls
  output reg                         global_tristate_hold,
  output reg                         global_write_enable,
  output reg                         block_memory_enable,
  output reg                         config_pins_dedicated,
  output reg                         readback_grant,
  output reg                         partial_grant
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam SYNC_W = 2 + `CLOCK_MANAGERS + `IMPEDANCE_BANKS;

  reg  [31:0]       config_word;        // Startup options
  reg  [31:0]       user_identification;// Revision code
  reg  [2:0]        phase;              // Current startup phase
  reg               running;            // Sequence in progress
  reg               finished;           // Done state reached
  reg               done_pipe_copy;     // Done pin copy taken on a startup edge
  reg               done_release;       // Done pin no longer held low
  reg               release_pending;    // Done release waiting a startup edge
  reg               next_hold;          // Next tristate hold
  reg               next_we;            // Next write enable
  reg               stall_lock;         // Waiting for clock managers
  reg               stall_match;        // Waiting for impedance match
  reg  [31:0]       next_rdata;         // Read data mux

  wire [SYNC_W-1:0] sync_out;           // Synchronised pin levels
  wire              done_sync;          // Done line level
  wire              user_sync;          // User clock level
  wire              scan_sync;          // Scan clock level
  wire              all_locked;         // Every clock manager locked
  wire              all_matched;        // Every bank matched
  wire              tick;               // Startup clock edge
  wire              cclk_level;         // Internal oscillator
  wire              done_input_sampled; // Done as seen by the sequencer
  wire              write_hit;          // Write completes this edge
  wire              access_wait;        // Access phase, answer not yet given

  // Field views of the configuration word
  wire [2:0] tristate_release_phase = config_word[`CFG_TRI_LSB +: 3];
  wire [2:0] write_enable_phase     = config_word[`CFG_WE_LSB +: 3];
  wire [2:0] done_release_phase     = config_word[`CFG_DONE_LSB +: 3];
  wire [2:0] lock_wait_phase        = config_word[`CFG_LOCK_LSB +: 3];
  wire [2:0] match_wait_phase       = config_word[`CFG_MATCH_LSB +: 3];
  wire       done_pipeline_enable   = config_word[`CFG_PIPE_BIT];
  wire       drive_done             = config_word[`CFG_DRIVE_BIT];
  wire       persist                = config_word[`CFG_PERSIST_BIT];
  wire [1:0] security_level         = config_word[`CFG_SEC_LSB +: 2];
  wire [1:0] startup_clock_select   = config_word[`CFG_CLKSEL_LSB +: 2];
  wire       master_mode            = config_word[`CFG_MASTER_BIT];

  // --------------------------------------------------------------------------
  // Pin synchronisers and startup clock
  // --------------------------------------------------------------------------
  sync_bank #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({impedance_calibration_match, clock_manager_locked, scan_test_clock, user_startup_clock}),
    .sync_out (sync_out)
  );

  assign user_sync   = sync_out[0];
  assign scan_sync   = sync_out[1];
  assign all_locked  = &sync_out[2 +: `CLOCK_MANAGERS];
  assign all_matched = &sync_out[2 + `CLOCK_MANAGERS +: `IMPEDANCE_BANKS];

  // Done pin needs its own pair so the pipelined copy reads a settled level
  sync_bank #(
    .WIDTH    (1)
  ) u_done_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (done_pin_in),
    .sync_out (done_sync)
  );

  startup_tick_gen u_tick (
    .clk          (clk),
    .rst          (rst),
    .clock_select (startup_clock_select),
    .user_sync    (user_sync),
    .scan_sync    (scan_sync),
    .cclk_level   (cclk_level),
    .tick         (tick)
  );

  // Pipelined mode uses the copy taken on a startup edge
  assign done_input_sampled = done_pipeline_enable ? done_pipe_copy : done_sync;

  // --------------------------------------------------------------------------
  // APB slave, one wait state so read data comes from a flop
  // --------------------------------------------------------------------------
  assign access_wait = psel & penable & ~pready;
  assign write_hit   = psel & penable & pready & pwrite & ~pslverr;

  // Read mux; status word shows the sequencer state
  always @*
  begin
    case (paddr)
      `ADDR_CONFIG:  next_rdata = config_word;
      `ADDR_USER_IDENTIFICATION: next_rdata = user_identification;
      `ADDR_COMMAND: next_rdata = 32'h0000_0000;
      `ADDR_STATUS:  next_rdata = {22'h00_0000, stall_match, stall_lock, done_input_sampled,
                                   global_write_enable, global_tristate_hold, finished, running, phase};
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  // Answer handshake; unmapped addresses answer with an error
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (access_wait)
    begin
      pready  <= 1'b1;
      pslverr <= (paddr > `ADDR_STATUS) | (paddr[1:0] != 2'h0) | (pwrite & (paddr == `ADDR_STATUS));
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writable registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_word         <= `CFG_RESET;
      user_identification <= 32'h0000_0000;
    end
    else if (write_hit)
    begin
      if (paddr == `ADDR_CONFIG)
        config_word <= pwdata & `CFG_MASK;
      if (paddr == `ADDR_USER_IDENTIFICATION)
        user_identification <= pwdata;
    end
  end

  // --------------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------------
  // Stall only in the selected phase; code 7 means no stall
  always @*
  begin
    stall_lock  = running & (lock_wait_phase != `PHASE_NO_STALL) &
                  (phase == lock_wait_phase) & ~all_locked;
    stall_match = running & (match_wait_phase != `PHASE_NO_STALL) &
                  (phase == match_wait_phase) & ~all_matched;
  end

  // Start writes restart at phase 0; a start while running is ignored
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase    <= 3'h0;
      running  <= 1'b0;
      finished <= 1'b0;
    end
    else if (write_hit & (paddr == `ADDR_COMMAND) & pwdata[`CMD_START_BIT] & ~running)
    begin
      phase    <= 3'h0;
      running  <= 1'b1;
      finished <= 1'b0;
    end
    else if (running & tick & ~stall_lock & ~stall_match)
    begin
      if (phase != `PHASE_FINAL)
        phase <= phase + 3'h1;
      else if (done_input_sampled & done_release)
      begin
        // Final phase holds until the shared line is high
        running  <= 1'b0;
        finished <= 1'b1;
      end
    end
  end

  // Done pipeline copy moves only on startup edges
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      done_pipe_copy <= 1'b0;
    else if (tick)
      done_pipe_copy <= done_sync;
  end

  // --------------------------------------------------------------------------
  // Global tristate and write enable
  // --------------------------------------------------------------------------
  // Phase codes 1..6 act on that phase, 7 follows done, 0 keeps the value
  always @*
  begin
    next_hold = global_tristate_hold;
    next_we   = global_write_enable;
    if (running & tick)
    begin
      if (tristate_release_phase == `PHASE_DONE)
      begin
        if (done_input_sampled)
          next_hold = 1'b0;
      end
      else if ((tristate_release_phase != `PHASE_KEEP) & (phase == tristate_release_phase))
        next_hold = 1'b0;
      if (write_enable_phase == `PHASE_DONE)
      begin
        if (done_input_sampled)
          next_we = 1'b1;
      end
      else if (write_enable_phase == `PHASE_KEEP)
        next_we = global_write_enable;
      else if (phase == write_enable_phase)
        next_we = 1'b1;
    end
  end

  // Block memories follow the write enable in the same edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      global_tristate_hold <= 1'b1;
      global_write_enable  <= 1'b0;
      block_memory_enable  <= 1'b0;
    end
    else
    begin
      global_tristate_hold <= next_hold;
      global_write_enable  <= next_we;
      block_memory_enable  <= next_we;
    end
  end

  // --------------------------------------------------------------------------
  // Done pin release
  // --------------------------------------------------------------------------
  // Pipelining postpones the release by one more startup edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_release    <= 1'b0;
      release_pending <= 1'b0;
    end
    else if (write_hit & (paddr == `ADDR_COMMAND) & pwdata[`CMD_START_BIT] & ~running)
    begin
      done_release    <= 1'b0;
      release_pending <= 1'b0;
    end
    else if (running & tick)
    begin
      if (release_pending)
        done_release <= 1'b1;
      else if (phase == done_release_phase)
      begin
        if (done_pipeline_enable)
          release_pending <= 1'b1;
        else
          done_release <= 1'b1;
      end
    end
  end

  // Held low before release; afterwards driven high or left to the pull-up.
  // Other devices may still hold the line low, which stalls the final phase.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_pin_out <= 1'b0;
      done_pin_oe  <= 1'b1;
    end
    else
    begin
      done_pin_out <= done_release & drive_done;
      done_pin_oe  <= ~done_release | drive_done;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration clock pin, security and persist
  // --------------------------------------------------------------------------
  // Readback and partial writes need the port, so persist gates both
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cclk_pin_out          <= 1'b0;
      cclk_pin_oe           <= 1'b0;
      config_pins_dedicated <= 1'b1;
      readback_grant        <= 1'b0;
      partial_grant         <= 1'b0;
    end
    else
    begin
      cclk_pin_out          <= cclk_level & master_mode;
      cclk_pin_oe           <= master_mode;
      config_pins_dedicated <= ~finished | persist;
      readback_grant        <= readback_request & (~finished | persist) &
                               (security_level == `SEC_NONE);
      partial_grant         <= partial_request & (~finished | persist) &
                               (security_level != `SEC_READBACK_PART) &
                               (security_level != 2'h3);
    end
  end

endmodule // config_startup_sequencer

// [logic/startup_defs.vh]
`ifndef STARTUP_DEFS_VH
`define STARTUP_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADDR_CONFIG        12'h000
`define ADDR_USER_IDENTIFICATION       12'h004
`define ADDR_COMMAND       12'h008
`define ADDR_STATUS        12'h00c

// ----------------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------------
`define CFG_TRI_LSB        0
`define CFG_WE_LSB         4
`define CFG_DONE_LSB       8
`define CFG_LOCK_LSB       12
`define CFG_MATCH_LSB      16
`define CFG_PIPE_BIT       20
`define CFG_DRIVE_BIT      21
`define CFG_PERSIST_BIT    22
`define CFG_SEC_LSB        24
`define CFG_CLKSEL_LSB     26
`define CFG_MASTER_BIT     28
`define CFG_RESET          32'h0007_7465
`define CFG_MASK           32'h1fff_7777

// ----------------------------------------------------------------------------
// Phase setting codes (3 bits)
// ----------------------------------------------------------------------------
`define PHASE_KEEP         3'h0
`define PHASE_DONE         3'h7
`define PHASE_NO_STALL     3'h7
`define PHASE_FINAL        3'h7

// Security levels
`define SEC_NONE           2'h0
`define SEC_READBACK       2'h1
`define SEC_READBACK_PART  2'h2

// Startup clock sources
`define CLKSEL_CCLK        2'h0
`define CLKSEL_USER        2'h1
`define CLKSEL_SCAN        2'h2

// Command bits
`define CMD_START_BIT      0

// ----------------------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------------------
`define CLOCK_MANAGERS     4
`define IMPEDANCE_BANKS    4
`define CLK_PERIOD_NS      10
`define CCLK_HALF_NS       125
`define CCLK_HALF_CYCLES   (`CCLK_HALF_NS / `CLK_PERIOD_NS)
`define CCLK_CNT_W         8

`endif

// [logic/sync_bank.v]
`timescale 1ns/1ps
`include "startup_defs.vh"

// ----------------------------------------------------------------------------
// Two-flop synchroniser bank, one pair per bit
// ----------------------------------------------------------------------------
module sync_bank #(
  parameter WIDTH = 1               // Bits in the bank
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bit_sync
      reg meta;                     // First stage, read only by second stage
      reg stable;                   // Second stage, safe to use
      // Two stages give the metastable first stage a full cycle to settle
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end
        else
        begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // sync_bank

// [logic/startup_tick_gen.v]
`timescale 1ns/1ps
`include "startup_defs.vh"

// ----------------------------------------------------------------------------
// Startup clock source: internal divider, user clock or scan test clock
// ----------------------------------------------------------------------------
module startup_tick_gen (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] clock_select,   // Startup clock source
  input  wire       user_sync,      // Synchronised user clock level
  input  wire       scan_sync,      // Synchronised scan test clock level
  output reg        cclk_level,     // Internal oscillator level
  output reg        tick            // One pulse per selected rising edge
);

  reg [`CCLK_CNT_W-1:0] div_count;  // Half period counter
  reg                   user_prev;  // Last user clock level
  reg                   scan_prev;  // Last scan clock level
  reg                   next_tick;  // Edge seen this cycle

  // Divider standing in for the internal oscillator
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_count  <= {`CCLK_CNT_W{1'b0}};
      cclk_level <= 1'b0;
    end
    else if (div_count == `CCLK_HALF_CYCLES - 1)
    begin
      div_count  <= {`CCLK_CNT_W{1'b0}};
      cclk_level <= ~cclk_level;
    end
    else
      div_count <= div_count + 1'b1;
  end

  // Pick the rising edge of the chosen source
  always @*
  begin
    case (clock_select)
      `CLKSEL_USER: next_tick = user_sync & ~user_prev;
      `CLKSEL_SCAN: next_tick = scan_sync & ~scan_prev;
      default:      next_tick = (div_count == `CCLK_HALF_CYCLES - 1) & ~cclk_level;
    endcase
  end

  // Edge history and registered tick
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      user_prev <= 1'b0;
      scan_prev <= 1'b0;
      tick      <= 1'b0;
    end
    else
    begin
      user_prev <= user_sync;
      scan_prev <= scan_sync;
      tick      <= next_tick;
    end
  end

endmodule // startup_tick_gen

// [sim/startup_checker.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the startup sequencer
// ----------------------------------------------------------------------------
module startup_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic readback_request,
  input wire logic partial_request,
  input wire logic readback_grant,
  input wire logic partial_grant,
  input wire logic config_pins_dedicated,
  input wire logic global_tristate_hold,
  input wire logic global_write_enable,
  input wire logic block_memory_enable,
  input wire logic cclk_pin_out,
  input wire logic cclk_pin_oe
);
  logic [7:0] half_cnt;  // Cycles since the last oscillator edge
  logic       cclk_prev; // Oscillator level one cycle ago
  logic       cclk_seen; // First edge seen, so the count is whole

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Half period counter; the turn-on edge is partial, so start at a falling edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      half_cnt  <= 8'h00;
      cclk_prev <= 1'b0;
      cclk_seen <= 1'b0;
    end
    else
    begin
      cclk_prev <= cclk_pin_out;
      half_cnt  <= (cclk_pin_out != cclk_prev) ? 8'h01 : half_cnt + 8'h01;
      cclk_seen <= cclk_pin_oe & (cclk_seen | ((cclk_pin_out != cclk_prev) & ~cclk_pin_out));
    end
  end

  AST_BLOCK_MEM_TRACKS_WE: assert property (block_memory_enable == global_write_enable)
    else $error("block memory enable differs from write enable");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  AST_READY_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not two cycles after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_READBACK_CAUSE: assert property (readback_grant |-> $past(readback_request))
    else $error("readback granted without request");
  AST_PARTIAL_CAUSE: assert property (partial_grant |-> $past(partial_request))
    else $error("partial granted without request");
  AST_GRANT_DEDICATED: assert property (readback_grant || partial_grant |-> config_pins_dedicated)
    else $error("grant while pins are released");
  AST_CCLK_HALF: assert property (cclk_pin_oe && cclk_seen && cclk_pin_out != cclk_prev |->
    half_cnt == 8'h0c)
    else $error("oscillator half period not twelve cycles");

  cover property ($fell(global_tristate_hold));
  cover property ($rose(global_write_enable));
  cover property (readback_grant);
  cover property (partial_grant && !readback_grant);
endmodule // startup_checker

// [sim/done_line_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Shared done line: pull-up plus a second, slower device
// ----------------------------------------------------------------------------
module done_line_model (
  input  wire logic done_pin_out,
  input  wire logic done_pin_oe,
  input  wire logic other_unconfigured, // Other device still loading
  output wire logic done_pin_in
);
  // Low while either party pulls down; the other holds low until configured
  assign done_pin_in = ~((done_pin_oe & ~done_pin_out) | other_unconfigured);
endmodule // done_line_model

// [sim/config_startup_sequencer_tb.sv]
`timescale 1ns/1ps
`include "startup_defs.vh"
// ----------------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------------
module config_startup_sequencer_tb;
  logic        clk, rst, psel, penable, pwrite, other_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, r, c;
  logic        e, user_startup_clock, scan_test_clock, readback_request, partial_request;
  logic [3:0]  clock_manager_locked, impedance_calibration_match;
  wire  [31:0] prdata;
  wire         pready, pslverr, done_pin_in, done_pin_out, done_pin_oe, cclk_pin_out, cclk_pin_oe;
  wire         global_tristate_hold, global_write_enable, block_memory_enable;
  wire         config_pins_dedicated, readback_grant, partial_grant;
  int          miscompares, n_compared, cyc, t0, per;
  bit          stalled;
  // Settings to run: defaults, keep, drive, persist, security, clocks, pipe, master, waits
  logic [31:0] cfgs [13] = '{32'h0007_7465, 32'h0007_7405, 32'h0027_7400, 32'h0047_7465,
    32'h0147_7465, 32'h0247_7465, 32'h0407_7465, 32'h0807_7465, 32'h0017_7465,
    32'h1007_7465, 32'h0007_7477, 32'h0007_2465, 32'h0003_7465};

  config_startup_sequencer dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .done_pin_in, .done_pin_out, .done_pin_oe, .cclk_pin_out, .cclk_pin_oe,
    .user_startup_clock, .scan_test_clock, .clock_manager_locked, .impedance_calibration_match,
    .readback_request, .partial_request, .global_tristate_hold, .global_write_enable,
    .block_memory_enable, .config_pins_dedicated, .readback_grant, .partial_grant);
  done_line_model partner_u (.done_pin_out, .done_pin_oe, .other_unconfigured(other_busy), .done_pin_in);

  // ----------------------------------------------------------------------------
  // Clocks: user and scan clocks run free at unlike rates so a wrong pick shows
  // ----------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    user_startup_clock <= (cyc % 14) < 7;
    scan_test_clock <= (cyc % 18) < 9;
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the whole table needs well under this span
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  // ----------------------------------------------------------------------------
  // Main sequence: one fresh reset and full startup per setting word
  // ----------------------------------------------------------------------------
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, other_busy, cyc} = '0;
    {user_startup_clock, scan_test_clock, readback_request, partial_request} = '0;
    clock_manager_locked = 4'hf;
    impedance_calibration_match = 4'hf;
    rst = 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      c = cfgs[i];
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      if (i == 0)
      begin
        apb(1'b0, `ADDR_CONFIG, 32'h0);
        chk(r, 32'h0007_7465);
        chk({global_tristate_hold, global_write_enable, block_memory_enable}, 3'h4);
      end
      // Hold back whatever the setting waits for
      clock_manager_locked <= (c[14:12] == 3'h7) ? 4'hf : 4'h7;
      impedance_calibration_match <= (c[18:16] == 3'h7) ? 4'hf : 4'hb;
      other_busy <= (c[2:0] == 3'h7);
      stalled = c[14:12] != 3'h7 || c[18:16] != 3'h7 || c[2:0] == 3'h7;
      apb(1'b1, `ADDR_CONFIG, c);
      apb(1'b1, `ADDR_COMMAND, 32'h1);
      t0 = cyc;
      if (stalled)
      begin
        repeat (300) @(posedge clk);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        if (c[14:12] != 3'h7) chk({r[8], r[2:0]}, {1'b1, c[14:12]});
        if (c[18:16] != 3'h7) chk({r[9], r[2:0]}, {1'b1, c[18:16]});
        if (c[2:0] == 3'h7) chk(r[6:3], 4'h5);
        clock_manager_locked <= 4'hf;
        impedance_calibration_match <= 4'hf;
        other_busy <= 1'b0;
      end
      for (int n = 0; n < 300 && r[4] !== 1'b1; n++) apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(r[4], 1'b1);
      per = (c[27:26] == 2'h1) ? 14 : (c[27:26] == 2'h2) ? 18 : 24;
      if (!stalled) chk((cyc - t0 >= 7 * per) && (cyc - t0 <= 10 * per + 20), 1'b1);
      chk({global_tristate_hold, global_write_enable, block_memory_enable},
          {c[2:0] == 3'h0, c[6:4] != 3'h0, c[6:4] != 3'h0});
      chk({done_pin_oe, done_pin_in, config_pins_dedicated, cclk_pin_oe},
          {c[21], 1'b1, c[22], c[28]});
      @(posedge clk);
      readback_request <= 1'b1;
      partial_request <= 1'b1;
      @(posedge clk);
      readback_request <= 1'b0;
      partial_request <= 1'b0;
      #1 chk({readback_grant, partial_grant},
             {c[22] && c[25:24] == 2'h0, c[22] && c[25:24] < 2'h2});
    end
    // Identification word, unmapped place and read-only status
    apb(1'b1, `ADDR_USER_IDENTIFICATION, 32'ha5c3_0f17);
    apb(1'b0, `ADDR_USER_IDENTIFICATION, 32'h0);
    chk(r, 32'ha5c3_0f17);
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, `ADDR_STATUS, 32'hffff_ffff);
    chk(e, 1'b1);
    stop_test;
  end
endmodule // config_startup_sequencer_tb

bind config_startup_sequencer startup_checker chk_u (.clk, .rst, .psel, .penable, .pready, .pslverr,
  .readback_request, .partial_request, .readback_grant, .partial_grant, .config_pins_dedicated,
  .global_tristate_hold, .global_write_enable, .block_memory_enable, .cclk_pin_out, .cclk_pin_oe);
